/* hw/port4_irq_pullup_data.sv */
// Port pin interrupt, pull-up and data registers behind an AXI4-Lite slave.
// Assumes PIN_IN synchronous to CORE_CLK; pads resolve from PIN_OUT/PIN_OE.
`timescale 1ns/1ns

// Overview of operation
// (R1) Each pin has a read/write interrupt enable bit at its pin position.
// (R2) Each pin has a pending flag, 1 while its interrupt is pending.
// (R3) Writing zero to a pending bit clears it; writing one leaves it.
// (R4) Each pin has a read/write pull-up enable bit, 1 turns pull-up on.
// (R5) Eight-bit data register drives output values and reads pin levels.
// (R6) Bits 31 to 8 of every register are read-only and read zero.
// (R7) Registers at 0x40C, 0x410, 0x414, 0x41C; all reset to zero.
// (R8) Edge select bit: 0 picks falling edge, 1 picks rising edge.
// (R9) Selected edge on enabled pin sets pending; request while enabled flag set.
module port4_irq_pullup_data
	import port_irq_pkg::*;
(
	input  wire logic              CORE_CLK,
	input  wire logic              RST_N,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [DATA_W-1:0] S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	output logic [DATA_W-1:0]      S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	input  wire pin_vec_t          PIN_IN,
	output pin_vec_t               PIN_OUT,
	output pin_vec_t               PIN_OE,
	output pin_vec_t               PIN_PULLUP_EN,
	output logic                   IRQ
);

	port_state_s st;
	port_state_s next_st;
	pin_vec_t    edge_hits;
	edge_cfg_s   edge_cfg;
	pin_vec_t    pin_level;
	pin_vec_t    pend_clr;
	pin_vec_t    pend_keep;
	logic        wr_do;
	logic        wr_map;
	logic        wr_pend;
	logic        wr_pur;
	logic        wr_data;
	logic        wr_en;
	logic        wr_edge;
	logic        rd_map;
	logic [7:0]  rd_byte;

	// Edge detector settings: select in the upper half, enable in the lower
	assign edge_cfg = {st.edge_sel, st.en};

	// Edge detection on the pins
	pin_edge_detect u_edge (
		.clk       (CORE_CLK),
		.rst_n     (RST_N),
		.pin_level (PIN_IN),
		.cfg       (edge_cfg),
		.hit       (edge_hits)
	);

	// Pin level seen by software: driven value on outputs, pad on inputs
	assign pin_level = (st.dir & st.data) | (~st.dir & PIN_IN); // R5

	// Helper for the pending hold check
	assign pend_keep = st.pend & st.wbyte;

	// Next state: bus channels, register writes, pending flags, request
	always_comb begin
		next_st  = st;
		wr_do    = 1'b0;
		wr_map   = 1'b0;
		wr_pend  = 1'b0;
		wr_pur   = 1'b0;
		wr_data  = 1'b0;
		wr_en    = 1'b0;
		wr_edge  = 1'b0;
		pend_clr = 8'h00;
		rd_map   = 1'b0;
		rd_byte  = 8'h00;

		// Write address and data are taken independently
		if (S_AXI_AWVALID && st.awready) begin
			next_st.aw_full = 1'b1;
			next_st.waddr   = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && st.wready) begin
			next_st.w_full = 1'b1;
			next_st.wbyte  = S_AXI_WDATA[7:0];
			next_st.wstrb0 = S_AXI_WSTRB[0];
		end

		// Write sequencing
		case (st.wr_state)
			WR_IDLE: begin
				if (st.aw_full && st.w_full) begin
					wr_do            = 1'b1;
					next_st.aw_full  = 1'b0;
					next_st.w_full   = 1'b0;
					next_st.bvalid   = 1'b1;
					next_st.wr_state = WR_RESP;
				end
			end
			WR_RESP: begin
				if (S_AXI_BREADY) begin
					next_st.bvalid   = 1'b0;
					next_st.wr_state = WR_IDLE;
				end
			end
			default: begin
				next_st.wr_state = WR_IDLE;
			end
		endcase

		// Write address decode, word aligned
		if (st.waddr[11:2] == OFS_EDGE_SEL[11:2]) begin
			wr_map  = 1'b1;
			wr_edge = wr_do && st.wstrb0;
		end else if (st.waddr[11:2] == OFS_IRQ_EN[11:2]) begin
			wr_map = 1'b1;
			wr_en  = wr_do && st.wstrb0;
		end else if (st.waddr[11:2] == OFS_IRQ_PEND[11:2]) begin
			wr_map  = 1'b1;
			wr_pend = wr_do && st.wstrb0;
		end else if (st.waddr[11:2] == OFS_PULLUP[11:2]) begin
			wr_map = 1'b1;
			wr_pur = wr_do && st.wstrb0;
		end else if (st.waddr[11:2] == OFS_DATA[11:2]) begin
			wr_map  = 1'b1;
			wr_data = wr_do && st.wstrb0;
		end else if (st.waddr[11:2] == OFS_DIR[11:2]) begin
			wr_map = 1'b1;
			if (wr_do && st.wstrb0) begin
				next_st.dir = st.wbyte;
			end
		end else if (st.waddr[11:2] == OFS_IRQ_CLR[11:2]) begin
			wr_map = 1'b1;
			if (wr_do && st.wstrb0) begin
				pend_clr = st.wbyte;
			end
		end
		if (wr_do) begin
			next_st.bresp = wr_map ? RESP_OKAY : RESP_SLVERR;
		end

		// Register updates from the decode
		if (wr_edge) begin
			next_st.edge_sel = st.wbyte; // R8
		end
		if (wr_en) begin
			next_st.en = st.wbyte; // R1
		end
		if (wr_pend) begin
			pend_clr = ~st.wbyte; // R3
		end
		if (wr_pur) begin
			next_st.pur = st.wbyte; // R4
		end
		if (wr_data) begin
			next_st.data = st.wbyte; // R5
		end

		// Pending flags: a new edge wins over a clear in the same cycle
		next_st.pend = (st.pend & ~pend_clr) | edge_hits; // R2 R3 R9

		// Request stays high while an enabled flag is set
		next_st.irq = |(next_st.pend & next_st.en); // R9

		// Write channel readiness
		next_st.awready = (next_st.wr_state == WR_IDLE) && !next_st.aw_full;
		next_st.wready  = (next_st.wr_state == WR_IDLE) && !next_st.w_full;

		// Read address decode
		if (S_AXI_ARADDR[11:2] == OFS_EDGE_SEL[11:2]) begin
			rd_map  = 1'b1;
			rd_byte = st.edge_sel;
		end else if (S_AXI_ARADDR[11:2] == OFS_IRQ_EN[11:2]) begin
			rd_map  = 1'b1;
			rd_byte = st.en;
		end else if (S_AXI_ARADDR[11:2] == OFS_IRQ_PEND[11:2]) begin
			rd_map  = 1'b1;
			rd_byte = st.pend; // R2
		end else if (S_AXI_ARADDR[11:2] == OFS_PULLUP[11:2]) begin
			rd_map  = 1'b1;
			rd_byte = st.pur;
		end else if (S_AXI_ARADDR[11:2] == OFS_DATA[11:2]) begin
			rd_map  = 1'b1;
			rd_byte = pin_level; // R5
		end else if (S_AXI_ARADDR[11:2] == OFS_DIR[11:2]) begin
			rd_map  = 1'b1;
			rd_byte = st.dir;
		end else if (S_AXI_ARADDR[11:2] == OFS_IRQ_CLR[11:2]) begin
			rd_map  = 1'b1;
			rd_byte = 8'h00;
		end

		// Read sequencing
		case (st.rd_state)
			RD_IDLE: begin
				if (S_AXI_ARVALID && st.arready) begin
					next_st.rvalid   = 1'b1;
					next_st.rdata    = {RESERVED_ZERO, rd_byte}; // R6
					next_st.rresp    = rd_map ? RESP_OKAY : RESP_SLVERR;
					next_st.rd_state = RD_RESP;
				end
			end
			RD_RESP: begin
				if (S_AXI_RREADY) begin
					next_st.rvalid   = 1'b0;
					next_st.rdata    = RST_RDATA;
					next_st.rd_state = RD_IDLE;
				end
			end
			default: begin
				next_st.rd_state = RD_IDLE;
			end
		endcase
		next_st.arready = (next_st.rd_state == RD_IDLE);
	end

	// State register, all fields zero at reset
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st <= '0; // R7
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign S_AXI_AWREADY = st.awready;
	assign S_AXI_WREADY  = st.wready;
	assign S_AXI_BVALID  = st.bvalid;
	assign S_AXI_BRESP   = st.bresp;
	assign S_AXI_ARREADY = st.arready;
	assign S_AXI_RVALID  = st.rvalid;
	assign S_AXI_RRESP   = st.rresp;
	assign S_AXI_RDATA   = st.rdata;
	assign PIN_OUT       = st.data;
	assign PIN_OE        = st.dir;
	assign PIN_PULLUP_EN = st.pur; // R4
	assign IRQ           = st.irq;

	// Enable write lands in the enable register
	chk_enable_write: assert property ( // R1
		@(posedge CORE_CLK) disable iff (!RST_N)
		wr_en |=> st.en == $past(st.wbyte))
		else $error("enable register missed a write");

	// A hit sets its pending flag on the next edge
	chk_pend_set: assert property ( // R2
		@(posedge CORE_CLK) disable iff (!RST_N)
		(edge_hits != 8'h00) |=> (st.pend & $past(edge_hits)) == $past(edge_hits))
		else $error("edge hit did not set pending");

	// Written zeros clear pending unless a hit arrived
	chk_pend_clear: assert property ( // R3
		@(posedge CORE_CLK) disable iff (!RST_N)
		wr_pend |=> (st.pend & ~$past(st.wbyte) & ~$past(edge_hits)) == 8'h00)
		else $error("pending bit written with zero not cleared");

	// Written ones leave pending flags set
	chk_pend_keep: assert property ( // R3
		@(posedge CORE_CLK) disable iff (!RST_N)
		wr_pend |=> (st.pend & $past(pend_keep)) == $past(pend_keep))
		else $error("pending bit written with one was lost");

	// Pull-up write reaches the pull-up pins
	chk_pullup_write: assert property ( // R4
		@(posedge CORE_CLK) disable iff (!RST_N)
		wr_pur |=> PIN_PULLUP_EN == $past(st.wbyte))
		else $error("pull-up pins do not follow the write");

	// Data write reaches the output pins
	chk_data_write: assert property ( // R5
		@(posedge CORE_CLK) disable iff (!RST_N)
		wr_data |=> PIN_OUT == $past(st.wbyte))
		else $error("output pins do not follow the data write");

	// Upper bits of read data stay zero
	chk_resvd_zero: assert property ( // R6
		@(posedge CORE_CLK) disable iff (!RST_N)
		S_AXI_RVALID |-> S_AXI_RDATA[31:8] == RESERVED_ZERO)
		else $error("reserved read bits not zero");

	// Enable, pending, pull-up and data registers are zero right after reset
	chk_reset_zero: assert property ( // R7
		@(posedge CORE_CLK)
		$rose(RST_N) |-> (st.en == RST_PIN_REG) && (st.pend == RST_PIN_REG)
			&& (st.pur == RST_PIN_REG) && (st.data == RST_PIN_REG))
		else $error("register not zero after reset");

	// Edge select write lands in the select register
	chk_edge_write: assert property ( // R8
		@(posedge CORE_CLK) disable iff (!RST_N)
		wr_edge |=> st.edge_sel == $past(st.wbyte))
		else $error("edge select missed a write");

	// Request high while any enabled flag is set, low otherwise
	chk_irq_level: assert property ( // R9
		@(posedge CORE_CLK) disable iff (!RST_N)
		IRQ == (|(st.pend & st.en)))
		else $error("interrupt request does not match enabled flags");

	// Write response follows the write by one cycle
	chk_bresp_follow: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		wr_do |=> S_AXI_BVALID)
		else $error("write response late");

	// Write response holds until the master takes it
	chk_bresp_hold: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		(S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID)
		else $error("write response dropped before taken");

endmodule

/* include/port_irq_pkg.sv */
// Shared constants and types for the port pin interrupt, pull-up and data block.
// Assumes a 32-bit AXI4-Lite register bus and one 8-pin port on one clock.
package port_irq_pkg;

	// Widths
	localparam int NUM_PINS = 8;
	localparam int ADDR_W   = 12;
	localparam int DATA_W   = 32;
	localparam int PIN_MSB  = 7;
	localparam int PIN_LSB  = 0;

	// Register byte offsets from the port base
	localparam logic [ADDR_W-1:0] OFS_EDGE_SEL = 12'h408;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 12'h40C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_PEND = 12'h410;
	localparam logic [ADDR_W-1:0] OFS_PULLUP   = 12'h414;
	localparam logic [ADDR_W-1:0] OFS_DATA     = 12'h41C;
	localparam logic [ADDR_W-1:0] OFS_DIR      = 12'h420;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 12'h424;

	// Reset values
	localparam logic [7:0]        RST_PIN_REG  = 8'h00;
	localparam logic [DATA_W-1:0] RST_RDATA    = 32'h0000_0000;
	localparam logic [23:0]       RESERVED_ZERO = 24'h00_0000;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef logic [PIN_MSB:PIN_LSB] pin_vec_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RESP = 2'b01
	} wr_state_e;

	typedef enum logic {
		RD_IDLE = 1'b0,
		RD_RESP = 1'b1
	} rd_state_e;

	// Edge detector configuration
	typedef struct packed {
		pin_vec_t sel;
		pin_vec_t en;
	} edge_cfg_s;

	// Edge detector state
	typedef struct packed {
		pin_vec_t prev;
		pin_vec_t hit;
	} edge_state_s;

	// Whole state of the port block
	typedef struct packed {
		wr_state_e         wr_state;
		logic              aw_full;
		logic              w_full;
		logic [ADDR_W-1:0] waddr;
		logic [7:0]        wbyte;
		logic              wstrb0;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		rd_state_e         rd_state;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [DATA_W-1:0] rdata;
		pin_vec_t          en;
		pin_vec_t          pend;
		pin_vec_t          pur;
		pin_vec_t          data;
		pin_vec_t          edge_sel;
		pin_vec_t          dir;
		logic              irq;
	} port_state_s;

endpackage

/* hw/pin_edge_detect.sv */
// Per-pin edge detector producing one-cycle hit pulses for enabled pins.
// Assumes pin levels already synchronous to the clock.
`timescale 1ns/1ns
module pin_edge_detect
	import port_irq_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst_n,
	input  wire pin_vec_t  pin_level,
	input  wire edge_cfg_s cfg,
	output pin_vec_t       hit
);

	edge_state_s st;
	edge_state_s next_st;
	pin_vec_t    seen;

	// Selected transition per pin: rising when select is 1, falling when 0
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		assign seen[i] = cfg.sel[i] ? (pin_level[i] & ~st.prev[i])
		                            : (~pin_level[i] & st.prev[i]); // R8
	end

	// Next state
	always_comb begin
		next_st      = st;
		next_st.prev = pin_level;
		next_st.hit  = seen & cfg.en; // R9
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign hit = st.hit;

	// Rising edge with rising select and enable gives a hit
	chk_rise_detect: assert property ( // R8
		@(posedge clk) disable iff (!rst_n)
		(pin_level[0] && !st.prev[0] && cfg.sel[0] && cfg.en[0]) |=> hit[0])
		else $error("rising edge on pin 0 not flagged");

	// Falling edge with falling select and enable gives a hit
	chk_fall_detect: assert property ( // R8
		@(posedge clk) disable iff (!rst_n)
		(!pin_level[0] && st.prev[0] && !cfg.sel[0] && cfg.en[0]) |=> hit[0])
		else $error("falling edge on pin 0 not flagged");

	// No hit on a pin whose enable was off
	chk_gate_enable: assert property ( // R1
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> (hit & ~$past(cfg.en)) == 8'h00)
		else $error("hit on a disabled pin");

endmodule

/* bench/pin_pads.sv */
// Model of the eight pads outside the port: outside drivers and pull-ups.
// Assumes the port drives PIN_OUT, PIN_OE and PIN_PULLUP_EN from flops on clk.
`timescale 1ns/1ns
module pin_pads
	import port_irq_pkg::*;
(
	input  wire logic     clk,
	input  wire pin_vec_t ext_oe,
	input  wire pin_vec_t ext_val,
	input  wire pin_vec_t pin_out,
	input  wire pin_vec_t pin_oe,
	input  wire pin_vec_t pullup_en,
	output pin_vec_t      pin_in
);
	pin_vec_t last;

	// Floating pad shows the inverse of its last level
	always_ff @(posedge clk) begin
		last <= pin_in;
	end

	// Pad level: port driver, then outside driver, then pull-up
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			if (pin_oe[i]) begin
				pin_in[i] = pin_out[i];
			end else if (ext_oe[i]) begin
				pin_in[i] = ext_val[i];
			end else if (pullup_en[i]) begin
				pin_in[i] = 1'b1;
			end else begin
				pin_in[i] = ~last[i];
			end
		end
	end
endmodule

/* bench/port4_irq_pullup_data_tb.sv */
// Self-checking bench for the port interrupt, pull-up and data block.
// Assumes the pad model in pin_pads and the AXI4-Lite slave timing of the block.
`timescale 1ns/1ns
module port4_irq_pullup_data_tb import port_irq_pkg::*;;
	logic              clk     = 1'b0;
	logic              rst_n   = 1'b0;
	logic [ADDR_W-1:0] awaddr  = '0;
	logic [ADDR_W-1:0] araddr  = '0;
	logic [DATA_W-1:0] wdata   = '0;
	logic [3:0]        wstrb   = 4'h0;
	logic              awvalid = 1'b0;
	logic              wvalid  = 1'b0;
	logic              bready  = 1'b0;
	logic              arvalid = 1'b0;
	logic              rready  = 1'b0;
	pin_vec_t          ext_oe  = 8'hFF;
	pin_vec_t          ext_val = 8'hF0;
	logic              awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]        bresp, rresp;
	logic [DATA_W-1:0] rdata;
	pin_vec_t          pin_in, pin_out, pin_oe, pu_en;
	int                failures = 0;
	int                n_checks = 0;

	// Free-running core clock, 20 ns period
	always #10 clk = ~clk;

	port4_irq_pullup_data i_dut (.CORE_CLK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PIN_IN(pin_in),
		.PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULLUP_EN(pu_en), .IRQ(irq));

	pin_pads i_pads (.clk(clk), .ext_oe(ext_oe), .ext_val(ext_val), .pin_out(pin_out),
		.pin_oe(pin_oe), .pullup_en(pu_en), .pin_in(pin_in));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Write cycle; each handshake judged at the rising edge that takes it
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic b_hit;
		b_hit = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !b_hit; n++) begin
			@(posedge clk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
			end
			if (bvalid && bready) begin
				b_hit = 1'b1;
				r = bresp;
				bready <= 1'b0;
			end
		end
		if (!b_hit) begin
			failures++;
			report_and_stop();
		end
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic r_hit;
		r_hit = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !r_hit; n++) begin
			@(posedge clk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
			end
			if (rvalid && rready) begin
				r_hit = 1'b1;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
		if (!r_hit) begin
			failures++;
			report_and_stop();
		end
	endtask

	// Full-word write expecting OKAY
	task automatic wok(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, 4'hF, r);
		check("bresp", r, RESP_OKAY);
	endtask

	// Read expecting OKAY and a given word
	task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check(what, d, exp);
		check("rresp", r, RESP_OKAY);
	endtask

	// Pin change applied after a rising edge, then three edges pass for the detector and pending flags
	task automatic pins(input pin_vec_t v);
		@(posedge clk);
		ext_val <= v;
		repeat (3) @(posedge clk);
	endtask

	task automatic t_reset();
		rchk("en rst", OFS_IRQ_EN, 32'h0000_0000);
		rchk("pend rst", OFS_IRQ_PEND, 32'h0000_0000);
		rchk("pur rst", OFS_PULLUP, 32'h0000_0000);
		check("pur pins rst", pu_en, 8'h00);
		check("irq rst", irq, 1'b0);
	endtask

	task automatic t_rw();
		logic [31:0] d;
		logic [1:0]  r;
		wok(OFS_IRQ_EN, 32'hFFFF_FFA5);
		wok(OFS_PULLUP, 32'hFFFF_FFA5);
		wok(OFS_DATA, 32'hFFFF_FF5A);
		rchk("en rw", OFS_IRQ_EN, 32'h0000_00A5);
		rchk("pur rw", OFS_PULLUP, 32'h0000_00A5);
		check("pur pins", pu_en, 8'hA5);
		check("pin out", pin_out, 8'h5A);
		wok(OFS_DIR, 32'h0000_00FF);
		check("pin oe", pin_oe, 8'hFF);
		rchk("data rw", OFS_DATA, 32'h0000_005A);
		wok(OFS_DIR, 32'h0000_0000);
		check("pin oe off", pin_oe, 8'h00);
		wr(OFS_IRQ_EN, 32'h0000_0000, 4'h0, r);
		check("strb b", r, RESP_OKAY);
		rchk("en strb", OFS_IRQ_EN, 32'h0000_00A5);
		wr(12'h418, 32'h0000_00FF, 4'hF, r);
		check("unmapped b", r, RESP_SLVERR);
		rd(12'h418, d, r);
		check("unmapped r", r, RESP_SLVERR);
		check("unmapped d", d, 32'h0000_0000);
	endtask

	task automatic t_pins();
		pins(8'h3C);
		rchk("data in", OFS_DATA, 32'h0000_003C);
		@(posedge clk);
		ext_oe <= 8'h7F;
		rchk("pullup hi", OFS_DATA, 32'h0000_00BC);
		@(posedge clk);
		ext_oe <= 8'hFF;
		pins(8'hF0);
	endtask

	task automatic t_irq();
		logic [1:0] r;
		wok(OFS_EDGE_SEL, 32'h0000_000F);
		wok(OFS_IRQ_EN, 32'h0000_0055);
		wok(OFS_IRQ_PEND, 32'h0000_0000);
		rchk("pend clr", OFS_IRQ_PEND, 32'h0000_0000);
		check("irq idle", irq, 1'b0);
		pins(8'h0F);
		rchk("pend set", OFS_IRQ_PEND, 32'h0000_0055);
		check("irq set", irq, 1'b1);
		wr(OFS_IRQ_PEND, 32'h0000_00FE, 4'hF, r);
		rchk("pend one", OFS_IRQ_PEND, 32'h0000_0054);
		check("irq kept", irq, 1'b1);
		wok(OFS_IRQ_CLR, 32'h0000_0004);
		rchk("pend w1c", OFS_IRQ_PEND, 32'h0000_0050);
		wok(OFS_IRQ_PEND, 32'h0000_0000);
		check("irq clr", irq, 1'b0);
		pins(8'hF0);
		rchk("pend other", OFS_IRQ_PEND, 32'h0000_0000);
		wok(OFS_IRQ_EN, 32'h0000_0000);
		pins(8'h0F);
		rchk("pend mask", OFS_IRQ_PEND, 32'h0000_0000);
		check("irq mask", irq, 1'b0);
	endtask

	// Reset in mid-run with registers written, then the reset checks again
	task automatic t_rst_mid();
		wok(OFS_IRQ_EN, 32'h0000_00FF);
		wok(OFS_PULLUP, 32'h0000_00FF);
		check("pur pins set", pu_en, 8'hFF);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
	endtask

	// Reset for 20 cycles, then the scenarios
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_rw();
		t_pins();
		t_irq();
		t_rst_mid();
		report_and_stop();
	end
endmodule
